/* bench/iep_core_model.sv */
// Core side model: takes a request after a set latency, returns later.
// Assumes pclk domain and the bench enabling it through serve.
`timescale 1ns/1ps
module iep_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic serve,
    input wire logic [3:0] lat,
    // Core link
    input wire logic irq_req,
    output logic irq_ack,
    output logic irq_done
);
    initial
    begin
        irq_ack = 1'b0;
        irq_done = 1'b0;
        forever
        begin
            @(posedge pclk);
            if (serve && presetn && irq_req === 1'b1)
            begin
                repeat (lat) @(posedge pclk);
                irq_ack <= 1'b1;
                @(posedge pclk);
                irq_ack <= 1'b0;
                repeat (20) @(posedge pclk);
                irq_done <= 1'b1;
                @(posedge pclk);
                irq_done <= 1'b0;
            end
        end
    end
endmodule : iep_core_model

/* bench/iep_top_test.sv */
// Self-checking bench for the interrupt enable and priority block.
// Assumes APB with zero wait states and the core model beside it.
`timescale 1ns/1ps
module iep_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] periph_req = 16'h0;
    logic missing_clock_event = 1'b0;
    logic clock_calendar_flag = 1'b0;
    logic serial1_flag = 1'b0;
    logic spi_flag = 1'b0;
    logic external_line_a = 1'b0;
    logic [15:0] external_line_b = 16'h0;
    logic irq_req;
    logic [15:0] irq_vector;
    logic [1:0] irq_level;
    logic irq_ack;
    logic irq_done;
    logic serve = 1'b0;
    logic [3:0] lat = 4'h0;
    logic [31:0] rdat;
    logic rerr;
    logic [7:0] t;
    logic [7:0] val [10];
    logic [31:0] pr;
    logic [15:0] rq;
    logic [15:0] mask;
    int failures = 0;
    int total_checks = 0;
    int j;
    int w;
    logic [9:0] regs [10] = '{iep_pkg::IDX_TCTRL, iep_pkg::IDX_PRIO0, iep_pkg::IDX_PRIO1,
        iep_pkg::IDX_PRIO2, iep_pkg::IDX_PRIO3, iep_pkg::IDX_IEMAIN, iep_pkg::IDX_P1EN,
        iep_pkg::IDX_P1FLG, iep_pkg::IDX_MXEN, iep_pkg::IDX_MXFLG};

    always #4 pclk = ~pclk;

    iep_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .clock_calendar_flag(clock_calendar_flag),
        .serial1_flag(serial1_flag), .spi_flag(spi_flag),
        .missing_clock_event(missing_clock_event),
        .external_line_a(external_line_a), .external_line_b(external_line_b),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
        .irq_ack(irq_ack), .irq_done(irq_done)
    );

    iep_core_model core (
        .pclk(pclk), .presetn(presetn), .serve(serve), .lat(lat),
        .irq_req(irq_req), .irq_ack(irq_ack), .irq_done(irq_done)
    );

    task chk(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the slave
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-raises psel in this step
        @(posedge pclk);
    endtask : apb

    function automatic logic exp_hit(logic [1:0] sel, logic rise);
        return sel[1] | (sel[0] ? !rise : rise);
    endfunction : exp_hit

    // Highest level wins, lower source index on a tie
    function automatic int win(logic [15:0] req, logic [31:0] p);
        int b;
        b = 0;
        for (int i = 0; i < 16; i++)
            if (req[i] && (!req[b] || p[2*i+:2] > p[2*b+:2]))
                b = i;
        return b;
    endfunction : win

    task tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #200000;
        failures++;
        tally_and_finish;
    end

    initial
    begin
        void'($urandom(32'hfdfe));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, regs[i], 8'h00);
            chk({rerr, rdat}, 33'h0);
        end
        for (int i = 1; i < 9; i++)
        begin
            val[i] = 8'($urandom);
            if (i != 7)
            begin
                apb(1'b1, regs[i], val[i]);
                apb(1'b0, regs[i], 8'h00);
                chk(rdat, (i == 5) ? val[i] & iep_pkg::IE_WMASK : val[i]);
            end
        end
        apb(1'b1, 10'h001, 8'hff);
        chk(rerr, 1'b1);
        apb(1'b0, 10'h001, 8'h00);
        chk({rerr, rdat}, 33'h100000000);
        // Missing clock flag held while disabled
        apb(1'b1, iep_pkg::IDX_IEMAIN, 8'h20);
        missing_clock_event <= 1'b1;
        @(posedge pclk);
        missing_clock_event <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(irq_req, 1'b0);
        apb(1'b0, iep_pkg::IDX_TCTRL, 8'h00);
        chk(rdat, 32'h40);
        apb(1'b1, iep_pkg::IDX_IEMAIN, 8'ha0);
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b1);
        chk(irq_vector, iep_pkg::VEC_BASE);
        chk(irq_level, val[1][1:0]);
        apb(1'b1, iep_pkg::IDX_TCTRL, 8'h40);
        apb(1'b0, iep_pkg::IDX_TCTRL, 8'h00);
        chk(rdat, 32'h40);
        apb(1'b1, iep_pkg::IDX_TCTRL, 8'h00);
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b0);
        // Edge selection on both lines
        j = $urandom_range(15, 0);
        apb(1'b1, iep_pkg::IDX_IEMAIN, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            for (int r = 1; r >= 0; r--)
            begin
                apb(1'b1, iep_pkg::IDX_TCTRL, {3'h0, s[1:0], 1'b0, s[1:0]});
                apb(1'b1, iep_pkg::IDX_P1FLG, 8'h00);
                apb(1'b1, iep_pkg::IDX_MXFLG, 8'h00);
                external_line_a <= r[0];
                external_line_b[j] <= r[0];
                repeat (6) @(posedge pclk);
                apb(1'b0, iep_pkg::IDX_TCTRL, 8'h00);
                chk(rdat[2], exp_hit(s[1:0], r[0]));
                apb(1'b0, iep_pkg::IDX_P1FLG, 8'h00);
                t = rdat[7:0];
                apb(1'b0, iep_pkg::IDX_MXFLG, 8'h00);
                chk({rdat[7:0], t}, 32'(exp_hit(s[1:0], r[0])) << j);
            end
        end
        // Line b request from one enabled pin
        apb(1'b1, iep_pkg::IDX_TCTRL, 8'h00);
        external_line_b[j] <= 1'b1;
        repeat (6) @(posedge pclk);
        mask = 16'h1 << j;
        apb(1'b1, iep_pkg::IDX_P1EN, mask[7:0]);
        apb(1'b1, iep_pkg::IDX_MXEN, mask[15:8]);
        apb(1'b1, iep_pkg::IDX_IEMAIN, 8'h84);
        repeat (3) @(posedge pclk);
        chk({irq_req, irq_vector}, 17'h10013);
        apb(1'b1, iep_pkg::IDX_P1FLG, 8'hff);
        apb(1'b1, iep_pkg::IDX_MXFLG, 8'hff);
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b1);
        apb(1'b1, iep_pkg::IDX_P1FLG, 8'h00);
        apb(1'b1, iep_pkg::IDX_MXFLG, 8'h00);
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b0);
        external_line_b[j] <= 1'b0;
        // Random arbitration rounds
        apb(1'b1, iep_pkg::IDX_IEMAIN, 8'h80);
        for (int k = 0; k < 9; k++)
        begin
            pr = $urandom;
            rq = (k == 0) ? 16'h8000 : (16'($urandom) & iep_pkg::SRC_OUTSIDE_MASK) | 16'h8;
            for (int g = 0; g < 4; g++)
                apb(1'b1, regs[1+g], pr[8*g+:8]);
            periph_req <= rq;
            repeat (3) @(posedge pclk);
            w = win(rq, pr);
            chk(irq_vector, 32'(iep_pkg::VEC_BASE) + w * 8);
            chk(irq_level, pr[2*w+:2]);
            periph_req <= 16'h0;
        end
        // Local flags wait for their own enable bits
        for (int f = 0; f < 3; f++)
        begin
            {clock_calendar_flag, serial1_flag, spi_flag} <= 3'h4 >> f;
            repeat (3) @(posedge pclk);
            chk(irq_req, 1'b0);
            apb(1'b1, iep_pkg::IDX_IEMAIN, (f == 0) ? 8'hc0 : (f == 1) ? 8'h90 : 8'h88);
            repeat (3) @(posedge pclk);
            mask = (f == 0) ? 16'h0043 : (f == 1) ? 16'h006b : 16'h0073;
            chk({irq_req, irq_vector}, {1'b1, mask});
            apb(1'b1, iep_pkg::IDX_IEMAIN, 8'h80);
        end
        {clock_calendar_flag, serial1_flag, spi_flag} <= 3'h0;
        // Preemption by level with a slow core
        apb(1'b1, iep_pkg::IDX_PRIO1, 8'h05);
        apb(1'b1, iep_pkg::IDX_PRIO2, 8'h80);
        lat <= 4'h8;
        serve <= 1'b1;
        periph_req <= 16'h0010;
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b1);
        repeat (12) @(posedge pclk);
        chk(irq_req, 1'b0);
        periph_req <= 16'h0030;
        repeat (4) @(posedge pclk);
        chk(irq_req, 1'b0);
        periph_req <= 16'h0830;
        repeat (4) @(posedge pclk);
        chk({irq_req, irq_level, irq_vector}, 19'h6005b);
        serve <= 1'b0;
        periph_req <= 16'h0;
        repeat (40) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, iep_pkg::IDX_IEMAIN, 8'h00);
        chk({irq_req, rdat}, 33'h0);
        tally_and_finish;
    end
endmodule : iep_top_test

/* logic/iep_edge_det.sv */
// One pin edge detector: two-stage synchroniser and selectable edge.
// Assumes pin is asynchronous to pclk.
`timescale 1ns/1ps
module iep_edge_det (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and selection
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    // One-cycle pulse on a selected edge
    output logic edge_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic [iep_pkg::WARM_CYCLES-1:0] warm;
    } iep_edge_s;

    iep_edge_s st_q;
    iep_edge_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
        st_d.warm = {st_q.warm[iep_pkg::WARM_CYCLES-2:0], 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    always_comb
    begin
        if (!st_q.warm[iep_pkg::WARM_CYCLES-1])
            edge_pulse = 1'b0;
        else if (edge_sel[1])
            edge_pulse = st_q.s2 ^ st_q.prev;
        else if (edge_sel == iep_pkg::EDGE_FALL)
            edge_pulse = st_q.prev & ~st_q.s2;
        else
            edge_pulse = st_q.s2 & ~st_q.prev;
    end
endmodule : iep_edge_det

/* logic/iep_pkg.sv */
// Register map, field positions and source numbering of the interrupt
// enable and priority block. Assumes a 32-bit APB slave, one word per register.
package iep_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_TCTRL = 10'h088;
    localparam logic [9:0] IDX_PRIO0 = 10'h08a;
    localparam logic [9:0] IDX_PRIO1 = 10'h08b;
    localparam logic [9:0] IDX_PRIO2 = 10'h08c;
    localparam logic [9:0] IDX_PRIO3 = 10'h08d;
    localparam logic [9:0] IDX_IEMAIN = 10'h0a8;
    localparam logic [9:0] IDX_P1EN = 10'h0d1;
    localparam logic [9:0] IDX_P1FLG = 10'h0d2;
    localparam logic [9:0] IDX_MXEN = 10'h0d3;
    localparam logic [9:0] IDX_MXFLG = 10'h0d4;

    // Reset value shared by every register
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_PRIO = 32'h0000_0000;

    // Main enable register fields
    localparam int IE_GLOBAL = 7;
    localparam int IE_CAL = 6;
    localparam int IE_MCLK = 5;
    localparam int IE_SER1 = 4;
    localparam int IE_SPI = 3;
    localparam int IE_EXTB = 2;
    localparam int IE_EXTA = 0;
    localparam logic [7:0] IE_WMASK = 8'hfd;

    // Timer control register fields
    localparam int TC_MCLK_FLAG = 6;
    localparam int TC_EXTB_SEL = 3;
    localparam int TC_EXTA_FLAG = 2;
    localparam int TC_EXTA_SEL = 0;

    // Edge select codes; bit 1 set means both edges
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // Sources, in fixed tie order
    localparam int NUM_SRC = 16;
    localparam int NUM_LVL = 4;
    localparam int SRC_LV_MCLK = 0;
    localparam int SRC_EXTA = 1;
    localparam int SRC_EXTB = 2;
    localparam int SRC_CAL_CAN = 8;
    localparam int SRC_I2C_SER1 = 13;
    localparam int SRC_SPI_SER2 = 14;
    localparam logic [15:0] SRC_OUTSIDE_MASK = 16'hfff9;

    // Vector of source n is VEC_BASE + n * 8
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_LAST = 16'h007b;
    localparam int VEC_SHIFT = 3;

    // Edge detector warm-up after reset
    localparam int WARM_CYCLES = 3;
endpackage : iep_pkg

/* logic/iep_top.sv */
// Interrupt enable, priority and external line register set with a
// prioritising request path to the core. Assumes APB master on pclk,
// peripheral flags on pclk, and asynchronous external pins.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module iep_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral flags; periph_req already gated by its own unit enables, the others gated here by main enable bits
    input wire logic [15:0] periph_req,
    input wire logic clock_calendar_flag,
    input wire logic serial1_flag,
    input wire logic spi_flag,
    input wire logic missing_clock_event,
    // External pins
    input wire logic external_line_a,
    input wire logic [15:0] external_line_b,
    // Core side
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [1:0] irq_level,
    input wire logic irq_ack,
    input wire logic irq_done
);
    typedef struct packed {
        logic [7:0] ie;
        logic [31:0] prio;
        logic mclk_flag;
        logic exta_flag;
        logic [1:0] extb_sel;
        logic [1:0] exta_sel;
        logic [15:0] pin_en;
        logic [15:0] pin_flag;
        logic [3:0] active;
        logic [31:0] rdata;
        logic req;
        logic [15:0] vec;
        logic [1:0] lvl;
    } iep_state_s;

    iep_state_s st_q;
    iep_state_s st_d;

    logic [9:0] idx;
    logic wr;
    logic hit;
    logic [7:0] rd_byte;
    logic exta_pulse;
    logic [15:0] extb_pulse;
    logic [15:0] src;
    logic best_valid;
    logic [1:0] best_lvl;
    logic [3:0] best_idx;
    logic cur_any;
    logic [1:0] cur_top;
    logic preempt_ok;
    logic mclk_clr;
    logic exta_clr;
    logic [15:0] pin_clr;

    assign idx = paddr[11:2];
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = st_q.rdata;
    assign irq_req = st_q.req;
    assign irq_vector = st_q.vec;
    assign irq_level = st_q.lvl;

    // Line a detector
    iep_edge_det u_edge_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_line_a),
        .edge_sel(st_q.exta_sel),
        .edge_pulse(exta_pulse)
    );

    // Line b: bits 7:0 port 1 pins 0..7; bits 15:8 are pins
    // P0.7, P4.1, P4.2, P3.6, P4.4, P4.5, P4.6, P0.4
    for (genvar g = 0; g < iep_pkg::NUM_SRC; g++)
    begin : g_pin
        iep_edge_det u_edge_b (
            .pclk(pclk),
            .presetn(presetn),
            .pin(external_line_b[g]),
            .edge_sel(st_q.extb_sel),
            .edge_pulse(extb_pulse[g])
        );
    end

    // Register read mux and address decode
    always_comb
    begin
        hit = 1'b1;
        case (idx)
            iep_pkg::IDX_TCTRL:
                rd_byte = {1'b0, st_q.mclk_flag, 1'b0, st_q.extb_sel,
                           st_q.exta_flag, st_q.exta_sel};
            iep_pkg::IDX_PRIO0: rd_byte = st_q.prio[7:0];
            iep_pkg::IDX_PRIO1: rd_byte = st_q.prio[15:8];
            iep_pkg::IDX_PRIO2: rd_byte = st_q.prio[23:16];
            iep_pkg::IDX_PRIO3: rd_byte = st_q.prio[31:24];
            iep_pkg::IDX_IEMAIN: rd_byte = st_q.ie & iep_pkg::IE_WMASK;
            iep_pkg::IDX_P1EN: rd_byte = st_q.pin_en[7:0];
            iep_pkg::IDX_P1FLG: rd_byte = st_q.pin_flag[7:0];
            iep_pkg::IDX_MXEN: rd_byte = st_q.pin_en[15:8];
            iep_pkg::IDX_MXFLG: rd_byte = st_q.pin_flag[15:8];
            default:
            begin
                rd_byte = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    // Software clears of hardware-set flags
    always_comb
    begin
        mclk_clr = 1'b0;
        exta_clr = 1'b0;
        pin_clr = 16'h0000;
        if (wr && idx == iep_pkg::IDX_TCTRL)
        begin
            mclk_clr = ~pwdata[iep_pkg::TC_MCLK_FLAG];
            exta_clr = ~pwdata[iep_pkg::TC_EXTA_FLAG];
        end
        if (wr && idx == iep_pkg::IDX_P1FLG)
            pin_clr[7:0] = ~pwdata[7:0];
        if (wr && idx == iep_pkg::IDX_MXFLG)
            pin_clr[15:8] = ~pwdata[7:0];
    end

    // Source requests
    always_comb
    begin
        src = periph_req & iep_pkg::SRC_OUTSIDE_MASK;
        src[iep_pkg::SRC_LV_MCLK] = src[iep_pkg::SRC_LV_MCLK]
            | (st_q.mclk_flag & st_q.ie[iep_pkg::IE_MCLK]);
        src[iep_pkg::SRC_EXTA] = st_q.exta_flag & st_q.ie[iep_pkg::IE_EXTA];
        src[iep_pkg::SRC_EXTB] = st_q.ie[iep_pkg::IE_EXTB]
            & (|(st_q.pin_flag & st_q.pin_en));
        src[iep_pkg::SRC_CAL_CAN] = src[iep_pkg::SRC_CAL_CAN]
            | (clock_calendar_flag & st_q.ie[iep_pkg::IE_CAL]);
        src[iep_pkg::SRC_I2C_SER1] = src[iep_pkg::SRC_I2C_SER1]
            | (serial1_flag & st_q.ie[iep_pkg::IE_SER1]);
        src[iep_pkg::SRC_SPI_SER2] = src[iep_pkg::SRC_SPI_SER2]
            | (spi_flag & st_q.ie[iep_pkg::IE_SPI]);
    end

    // Arbitration over level, then fixed order
    always_comb
    begin
        best_valid = 1'b0;
        best_lvl = 2'h0;
        best_idx = 4'h0;
        // Downward scan, lower index wins ties
        for (int i = iep_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            // Source n uses field bits 2n+1:2n
            if (src[i] && (!best_valid || st_q.prio[2*i +: 2] >= best_lvl))
            begin
                best_valid = 1'b1;
                best_lvl = st_q.prio[2*i +: 2];
                best_idx = 4'(i);
            end
        end
    end

    // Highest level now in service
    always_comb
    begin
        cur_any = |st_q.active;
        cur_top = 2'h0;
        for (int l = 0; l < iep_pkg::NUM_LVL; l++)
        begin
            if (st_q.active[l])
                cur_top = 2'(l);
        end
        preempt_ok = !cur_any || (best_lvl > cur_top);
    end

    // Next state
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = st_q.rdata;
        if (psel && !penable)
            st_d.rdata = {24'h000000, rd_byte};
        if (wr)
        begin
            case (idx)
                iep_pkg::IDX_TCTRL:
                begin
                    st_d.extb_sel = pwdata[iep_pkg::TC_EXTB_SEL +: 2];
                    st_d.exta_sel = pwdata[iep_pkg::TC_EXTA_SEL +: 2];
                end
                iep_pkg::IDX_PRIO0: st_d.prio[7:0] = pwdata[7:0];
                iep_pkg::IDX_PRIO1: st_d.prio[15:8] = pwdata[7:0];
                iep_pkg::IDX_PRIO2: st_d.prio[23:16] = pwdata[7:0];
                iep_pkg::IDX_PRIO3: st_d.prio[31:24] = pwdata[7:0];
                iep_pkg::IDX_IEMAIN: st_d.ie = pwdata[7:0] & iep_pkg::IE_WMASK;
                iep_pkg::IDX_P1EN: st_d.pin_en[7:0] = pwdata[7:0];
                iep_pkg::IDX_MXEN: st_d.pin_en[15:8] = pwdata[7:0];
                default:
                begin
                end
            endcase
        end
        // Set wins over a same-cycle clear
        st_d.mclk_flag = missing_clock_event | (st_q.mclk_flag & ~mclk_clr);
        st_d.exta_flag = exta_pulse | (st_q.exta_flag & ~exta_clr);
        st_d.pin_flag = extb_pulse | (st_q.pin_flag & ~pin_clr);
        // Service bookkeeping: end of routine, then new entry
        if (irq_done && cur_any)
            st_d.active[cur_top] = 1'b0;
        if (irq_ack && st_q.req)
            st_d.active[st_q.lvl] = 1'b1;
        st_d.req = st_q.ie[iep_pkg::IE_GLOBAL] & best_valid & preempt_ok;
        st_d.vec = iep_pkg::VEC_BASE
            + {9'h000, best_idx, 3'h0};
        st_d.lvl = best_lvl;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
            st_q.ie <= iep_pkg::RST_BYTE;
            st_q.prio <= iep_pkg::RST_PRIO;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    a_global_gate:
    assert property (@(posedge pclk) disable iff (!presetn)
        st_q.req |-> $past(st_q.ie[iep_pkg::IE_GLOBAL]))
    else $error("request raised while global enable was off");

    a_req_cause:
    assert property (@(posedge pclk) disable iff (!presetn)
        !st_q.ie[iep_pkg::IE_GLOBAL] || src == 16'h0000 |=> !st_q.req)
    else $error("request without an enabled pending source");

    a_mclk_set:
    assert property (@(posedge pclk) disable iff (!presetn)
        missing_clock_event |=> st_q.mclk_flag)
    else $error("missing clock event did not set its flag");

    a_flag_clear:
    assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == iep_pkg::IDX_TCTRL && !pwdata[iep_pkg::TC_EXTA_FLAG]
        && !exta_pulse |=> !st_q.exta_flag)
    else $error("write of zero did not clear line a flag");

    a_exta_set:
    assert property (@(posedge pclk) disable iff (!presetn)
        exta_pulse |=> st_q.exta_flag ##1 1'b1)
    else $error("selected line a edge did not set its flag");

    a_pending_kept:
    assert property (@(posedge pclk) disable iff (!presetn)
        st_q.exta_flag && !exta_clr |=> st_q.exta_flag)
    else $error("pending line a flag lost without a clear");

    a_same_level:
    assert property (@(posedge pclk) disable iff (!presetn)
        st_q.req && $past(cur_any) |-> st_q.lvl > $past(cur_top))
    else $error("request did not outrank the routine in service");

    a_vector_grid:
    assert property (@(posedge pclk) disable iff (!presetn)
        st_q.req |-> st_q.vec[2:0] == iep_pkg::VEC_BASE[2:0]
        && st_q.vec <= iep_pkg::VEC_LAST)
    else $error("vector off the eight-byte grid");

    a_pin_once:
    assert property (@(posedge pclk) disable iff (!presetn)
        extb_pulse[0] |=> !extb_pulse[0])
    else $error("one pin edge produced two pulses");

    a_pin_or:
    assert property (@(posedge pclk) disable iff (!presetn)
        st_q.ie[iep_pkg::IE_EXTB] && (|(st_q.pin_flag & st_q.pin_en))
        |-> src[iep_pkg::SRC_EXTB] ##1 st_q.req || $past(!preempt_ok)
        || !$past(st_q.ie[iep_pkg::IE_GLOBAL]) || $past(best_idx) < 4'h3)
    else $error("enabled pin flag did not reach line b request");
endmodule : iep_top
